/* hdl/tkrc_port.sv */
/*
  Timekeeping RAM with calendar clock behind an async byte-wide port.
  Assumes host pins arrive asynchronously and are synchronised here;
  power_fail_in is a comparator level from the supply monitor.
*/
`default_nettype none
module tkrc_port
  import tkrc_pkg::*;
#(
  parameter int RAM_WORDS = 32768,
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int TEST_HALF = TEST_HALF_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              write_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        data_in,
  output var  logic [7:0]        data_out,
  output var  logic              data_oe,
  input  wire logic              power_fail_in,
  output var  logic              power_fail_flag_n
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  tkrc_bus_type bus_m_q, bus_q;
  logic         pf_m_q, pf_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_m_q <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, din: '0};
      bus_q   <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, din: '0};
      pf_m_q  <= 1'b0;
      pf_q    <= 1'b0;
    end else begin
      bus_m_q <= '{sel_n: chip_sel_n, oe_n: out_en_n, we_n: write_n,
                   addr: addr, din: data_in};
      bus_q   <= bus_m_q;
      pf_m_q  <= power_fail_in;
      pf_q    <= pf_m_q;
    end
  end

  logic sel_act, rd_act, wr_act, wr_start, wr_prev_q;
  assign sel_act  = !bus_q.sel_n && !pf_q;
  assign rd_act   = sel_act && bus_q.we_n;
  assign wr_act   = sel_act && !bus_q.we_n;
  // a write commits once, at the later of the two falling edges
  assign wr_start = wr_act && !wr_prev_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wr_prev_q <= 1'b0;
    else     wr_prev_q <= wr_act;
  end

  // ------------------------------------------------------------
  // registers and storage
  // ------------------------------------------------------------
  logic [7:0]    ram_q [RAM_WORDS];
  logic [7:0]    ctrl_q;
  tkrc_time_type cnt_q, vis_q;
  logic          osc_stop_q, ftest_q;
  logic [31:0]   sec_div_q;
  logic [31:0]   tst_div_q;
  logic          tst_q;
  logic          tick;
  logic [2:0]    unused_q [7];   // spare bits of the clock bytes
  logic          wh_fall;
  logic          hold_wr;

  assign hold_wr = ctrl_q[WRITE_HOLD_POS];
  assign tick    = !osc_stop_q && (sec_div_q == 32'(SEC_CYCLES - 1));

  // plain RAM below the clock window
  always_ff @(posedge mclk) begin
    if (wr_start && bus_q.addr < CLOCK_CONTROL_OFS)
      ram_q[bus_q.addr] <= bus_q.din;
  end

  // control, stop and test bits; spare bits kept as RAM
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= 8'h00;
      osc_stop_q <= 1'b0;
      ftest_q    <= 1'b0;
      for (int i = 0; i < 7; i++) unused_q[i] <= 3'b000;
    end else if (wr_start) begin
      unique case (bus_q.addr)
        CLOCK_CONTROL_OFS: ctrl_q <= bus_q.din;
        SECONDS_COUNT_OFS: osc_stop_q <= bus_q.din[OSC_STOP_POS];
        MINUTES_COUNT_OFS: unused_q[0][0] <= bus_q.din[7];
        HOURS_COUNT_OFS:   unused_q[1][1:0] <= bus_q.din[7:6];
        WEEKDAY_COUNT_OFS: begin
          ftest_q <= bus_q.din[FREQ_TEST_POS];
          unused_q[2] <= {bus_q.din[7], bus_q.din[5:4]};
          unused_q[3][0] <= bus_q.din[3];
        end
        DAY_OF_MONTH_OFS:  unused_q[4][1:0] <= bus_q.din[7:6];
        MONTH_COUNT_OFS:   unused_q[5] <= bus_q.din[7:5];
        default: ;
      endcase
    end
  end

  assign wh_fall = wr_start && bus_q.addr == CLOCK_CONTROL_OFS
                   && hold_wr && !bus_q.din[WRITE_HOLD_POS];

  // ------------------------------------------------------------
  // timebase: one-second enable and 512 Hz test wave
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sec_div_q <= '0;
    else if (osc_stop_q) sec_div_q <= sec_div_q;
    else if (tick) sec_div_q <= '0;
    else sec_div_q <= sec_div_q + 32'd1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tst_div_q <= '0;
      tst_q     <= 1'b0;
    end else if (!osc_stop_q) begin
      if (tst_div_q == 32'(TEST_HALF - 1)) begin
        tst_div_q <= '0;
        tst_q     <= !tst_q;
      end else begin
        tst_div_q <= tst_div_q + 32'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // BCD calendar
  // ------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // leap every fourth year; year 00 counts as leap
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    // bcd multiple of four: even tens with units 0/4/8, odd tens with units 2/6
    leap = ({y[4], y[1:0]} == 3'b000) || ({y[4], y[1:0]} == 3'b110);
    unique case (m)
      8'h02:                      month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  endfunction

  tkrc_time_type nxt;
  always_comb begin
    nxt = cnt_q;
    if (cnt_q.sec == 8'h59) begin
      nxt.sec = 8'h00;
      if (cnt_q.min == 8'h59) begin
        nxt.min = 8'h00;
        if (cnt_q.hour == 8'h23) begin
          nxt.hour = 8'h00;
          nxt.wday = (cnt_q.wday == 8'h07) ? 8'h01 : bcd_inc(cnt_q.wday);
          if (cnt_q.mday == month_end(cnt_q.mon, cnt_q.year)) begin
            nxt.mday = 8'h01;
            if (cnt_q.mon == 8'h12) begin
              nxt.mon  = 8'h01;
              nxt.year = (cnt_q.year == 8'h99) ? 8'h00 : bcd_inc(cnt_q.year);
            end else begin
              nxt.mon = bcd_inc(cnt_q.mon);
            end
          end else begin
            nxt.mday = bcd_inc(cnt_q.mday);
          end
        end else begin
          nxt.hour = bcd_inc(cnt_q.hour);
        end
      end else begin
        nxt.min = bcd_inc(cnt_q.min);
      end
    end else begin
      nxt.sec = bcd_inc(cnt_q.sec);
    end
  end

  // internal counters run regardless of reads, read-hold or supply state; write-hold and oscillator stop halt them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '{sec: TIME_RESET, min: TIME_RESET, hour: TIME_RESET,
                 wday: DATE_RESET, mday: DATE_RESET, mon: DATE_RESET, year: TIME_RESET};
    end else if (wh_fall) begin
      cnt_q <= vis_q;
    end else if (tick && !hold_wr) begin
      cnt_q <= nxt;
    end
  end

  // visible copy: loaded by host under write-hold, else follows counters unless read-hold is set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vis_q <= '{sec: TIME_RESET, min: TIME_RESET, hour: TIME_RESET,
                 wday: DATE_RESET, mday: DATE_RESET, mon: DATE_RESET, year: TIME_RESET};
    end else if (hold_wr) begin
      if (wr_start) begin
        unique case (bus_q.addr)
          SECONDS_COUNT_OFS: vis_q.sec  <= {1'b0, bus_q.din[6:0]};
          MINUTES_COUNT_OFS: vis_q.min  <= {1'b0, bus_q.din[6:0]};
          HOURS_COUNT_OFS:   vis_q.hour <= {2'b00, bus_q.din[5:0]};
          WEEKDAY_COUNT_OFS: vis_q.wday <= {5'b00000, bus_q.din[2:0]};
          DAY_OF_MONTH_OFS:  vis_q.mday <= {2'b00, bus_q.din[5:0]};
          MONTH_COUNT_OFS:   vis_q.mon  <= {3'b000, bus_q.din[4:0]};
          YEAR_COUNT_OFS:    vis_q.year <= bus_q.din;
          default: ;
        endcase
      end
    end else if (!ctrl_q[READ_HOLD_POS]) begin
      vis_q <= cnt_q;
    end
  end

  // ------------------------------------------------------------
  // read path: ripple-through mux, drive gated by select and enable
  // ------------------------------------------------------------
  logic [7:0] rd_d;
  always_comb begin
    unique case (bus_q.addr)
      CLOCK_CONTROL_OFS: rd_d = ctrl_q;
      SECONDS_COUNT_OFS: rd_d = {osc_stop_q, vis_q.sec[6:1],
                                 ftest_q ? tst_q : vis_q.sec[0]};
      MINUTES_COUNT_OFS: rd_d = {unused_q[0][0], vis_q.min[6:0]};
      HOURS_COUNT_OFS:   rd_d = {unused_q[1][1:0], vis_q.hour[5:0]};
      WEEKDAY_COUNT_OFS: rd_d = {unused_q[2][2], ftest_q, unused_q[2][1:0],
                                 unused_q[3][0], vis_q.wday[2:0]};
      DAY_OF_MONTH_OFS:  rd_d = {unused_q[4][1:0], vis_q.mday[5:0]};
      MONTH_COUNT_OFS:   rd_d = {unused_q[5], vis_q.mon[4:0]};
      YEAR_COUNT_OFS:    rd_d = vis_q.year;
      default:           rd_d = ram_q[bus_q.addr];
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_out <= rd_d;
      data_oe  <= rd_act && !bus_q.oe_n;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) power_fail_flag_n <= 1'b1;
    else     power_fail_flag_n <= !pf_q;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence sel_rd_s;
    !bus_q.sel_n && bus_q.we_n && !bus_q.oe_n && !pf_q;
  endsequence

  drive_when_read_a: assert property (@(posedge mclk) disable iff (rst)
    sel_rd_s |=> data_oe) else $error("data not driven during read");
  no_drive_idle_a: assert property (@(posedge mclk) disable iff (rst)
    (bus_q.sel_n || !bus_q.we_n || bus_q.oe_n) |=> !data_oe)
    else $error("data driven outside read");
  pf_deselect_a: assert property (@(posedge mclk) disable iff (rst)
    pf_q |=> !data_oe) else $error("output driven in power fail");
  pf_flag_a: assert property (@(posedge mclk) disable iff (rst)
    pf_q |=> !power_fail_flag_n) else $error("power fail flag not low");
  osc_freeze_a: assert property (@(posedge mclk) disable iff (rst)
    osc_stop_q && !wh_fall |=> cnt_q == $past(cnt_q))
    else $error("counter moved while stopped");
  ctrl_store_a: assert property (@(posedge mclk) disable iff (rst)
    wr_start && bus_q.addr == CLOCK_CONTROL_OFS |=> ctrl_q == $past(bus_q.din))
    else $error("control byte not stored");
  read_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[READ_HOLD_POS] && !hold_wr |=> vis_q == $past(vis_q))
    else $error("visible time moved under read hold");
  wh_load_a: assert property (@(posedge mclk) disable iff (rst)
    wh_fall |=> cnt_q == $past(vis_q)) else $error("held time not loaded");
  ripple_a: assert property (@(posedge mclk) disable iff (rst)
    sel_rd_s ##1 sel_rd_s |-> data_out == $past(rd_d))
    else $error("read data not following address");
  pf_lock_a: assert property (@(posedge mclk) disable iff (rst)
    pf_q |-> !wr_start) else $error("write accepted in power fail");
  flag_release_a: assert property (@(posedge mclk) disable iff (rst)
    !pf_q |=> power_fail_flag_n) else $error("power fail flag stuck low");
  wave_stop_a: assert property (@(posedge mclk) disable iff (rst)
    osc_stop_q |=> $stable(tst_q)) else $error("test wave ran while stopped");
  write_once_a: assert property (@(posedge mclk) disable iff (rst)
    wr_start |=> !wr_start) else $error("write committed twice");
  wh_freeze_a: assert property (@(posedge mclk) disable iff (rst)
    hold_wr && !wh_fall |=> cnt_q == $past(cnt_q))
    else $error("counter moved under write hold");
  leap_day_a: assert property (@(posedge mclk) disable iff (rst)
    tick && !hold_wr && cnt_q.sec == 8'h59 && cnt_q.min == 8'h59
    && cnt_q.hour == 8'h23 && cnt_q.mon == 8'h02 && cnt_q.mday == 8'h28
    && cnt_q.year == 8'h04 |=> cnt_q.mday == 8'h29)
    else $error("leap day skipped");

endmodule
`default_nettype wire

/* hdl/tkrc_pkg.sv */
/*
  Constants and carrier types for the timekeeping RAM clock port.
  Assumes a 100 MHz mclk and a host that drives the async byte-wide port.
*/
// Behaviour
// - host may stop the oscillator any time
// - seconds bit 7 stops the oscillator
// - day bit 6 toggles seconds bit 0
// - data bit zero toggles during seconds read
// - control bit 7 write-hold, bit 6 read-hold
// - unused clock bits act as RAM
// - read when select low, strobe high
// - reads follow address without strobe edge
// - drive data only with select and enable
// - write while select and strobe low
// - write strobe fall disables read drive
// - power fail forces internal deselect
// - power fail flag low until nominal
// - clock keeps counting on battery
// - read-hold freezes view, counting continues
// - write-hold loads counters on release
// - visible registers buffered from counters
`default_nettype none
package tkrc_pkg;
  localparam int ADDR_W = 15;
  localparam logic [14:0] CLOCK_CONTROL_OFS = 15'h7ff8;
  localparam logic [14:0] SECONDS_COUNT_OFS = 15'h7ff9;
  localparam logic [14:0] MINUTES_COUNT_OFS = 15'h7ffa;
  localparam logic [14:0] HOURS_COUNT_OFS = 15'h7ffb;
  localparam logic [14:0] WEEKDAY_COUNT_OFS = 15'h7ffc;
  localparam logic [14:0] DAY_OF_MONTH_OFS = 15'h7ffd;
  localparam logic [14:0] MONTH_COUNT_OFS = 15'h7ffe;
  localparam logic [14:0] YEAR_COUNT_OFS = 15'h7fff;
  localparam int WRITE_HOLD_POS = 7;
  localparam int READ_HOLD_POS = 6;
  localparam int OSC_STOP_POS = 7;
  localparam int FREQ_TEST_POS = 6;
  localparam int CLK_HZ = 100_000_000;
  localparam int TEST_HZ = 512;
  // half period of the 512 Hz test square wave
  localparam int TEST_HALF_CYC = CLK_HZ / (2 * TEST_HZ);
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [7:0] TIME_RESET = 8'h00;
  localparam logic [7:0] DATE_RESET = 8'h01;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] mon;
    logic [7:0] year;
  } tkrc_time_type;

  typedef struct packed {
    logic       sel_n;
    logic       oe_n;
    logic       we_n;
    logic [14:0] addr;
    logic [7:0] din;
  } tkrc_bus_type;
endpackage
`default_nettype wire

/* dv/tkrc_host.sv */
/*
  Host bus model for the timekeeping RAM clock port.
  Assumes mclk from the bench; pins change 1 ns after a rising edge.
*/
`default_nettype none
module tkrc_host
  import tkrc_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic [7:0]   data_out,
  input  wire logic         data_oe,
  output var  tkrc_bus_type bus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000, din: 8'h00};
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic idle();
    bus.sel_n = 1'b1;
    bus.oe_n = 1'b1;
    step(3); // recovery with select high
  endtask
  // stays selected so the next call ripples to a new address
  task automatic sel_read(input logic [14:0] a, input logic oe_low, output logic [7:0] d);
    bus.we_n = 1'b1;
    bus.addr = a;
    bus.sel_n = 1'b0;
    bus.oe_n = !oe_low;
    step(4);
    d = data_out;
  endtask
  task automatic bus_read(input logic [14:0] a, output logic [7:0] d, output logic ok);
    step(1);
    bus.addr = a;
    bus.sel_n = 1'b0;
    bus.oe_n = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 8 && !ok; i++) begin
      step(1);
      ok = (data_oe === 1'b1);
      d = data_out;
    end
    idle();
  endtask
  task automatic bus_write(input logic [14:0] a, input logic [7:0] d, input logic oe_low,
                           output logic ok);
    step(1);
    bus.addr = a;
    bus.din = d;
    bus.oe_n = !oe_low; // high unless contention is the point
    ok = !oe_low;
    step(3); // address and data settle before the strobe
    bus.sel_n = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      step(1);
      ok = (data_oe === 1'b1);
    end
    bus.we_n = 1'b0;
    step(4);
    ok = ok && (data_oe === 1'b0);
    bus.we_n = 1'b1;
    idle(); // address held through the end of write
    // released data lines never show a stale copy
    bus.din = ~bus.din;
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/*
  Self-checking bench for the timekeeping RAM clock port.
  Assumes the host model in tkrc_host and short second and test counts.
*/
`default_nettype none
module tb_top
  import tkrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         mclk;
  logic         rst;
  logic         power_fail_in;
  tkrc_bus_type bus;
  logic [7:0]   data_out;
  logic         data_oe;
  logic         power_fail_flag_n;
  logic [7:0]   rd;
  logic [7:0]   prev;
  logic         ok;
  logic         last;
  int           toggles;
  int           err_count;
  int           total_checks;
  // sec..year loaded under write-hold, and the view one second later
  logic [7:0]   tval [7] = '{8'h59, 8'h59, 8'h23, 8'hb7, 8'h28, 8'he2, 8'h04};
  logic [7:0]   texp [7] = '{8'h00, 8'h00, 8'h00, 8'hb1, 8'h29, 8'he2, 8'h04};

  tkrc_port #(.SEC_CYCLES(20), .TEST_HALF(4)) uut (
    .mclk(mclk), .rst(rst), .chip_sel_n(bus.sel_n), .out_en_n(bus.oe_n), .write_n(bus.we_n),
    .addr(bus.addr), .data_in(bus.din), .data_out(data_out), .data_oe(data_oe),
    .power_fail_in(power_fail_in), .power_fail_flag_n(power_fail_flag_n));
  tkrc_host host (.mclk(mclk), .data_out(data_out), .data_oe(data_oe), .bus(bus));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // checks and report
  // ----------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    host.bus_read(a, rd, ok);
    chk1(ok, 1'b1);
    if (!ok) end_of_test(); // a read that never drove is a hang
    chk(rd, exp);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.bus_write(a, d, 1'b0, ok);
    chk1(ok, 1'b1);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_count = 0;
    total_checks = 0;
    rst = 1'b1;
    power_fail_in = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    rd_chk(CLOCK_CONTROL_OFS, 8'h00);
    rd_chk(MONTH_COUNT_OFS, 8'h01);
    rd_chk(YEAR_COUNT_OFS, 8'h00);
    wr(15'h0010, 8'ha5);
    wr(15'h7ff7, 8'h3c);
    host.sel_read(15'h0010, 1'b1, rd);
    chk(rd, 8'ha5);
    host.sel_read(15'h7ff7, 1'b1, rd); // address moves, no strobe edge
    chk(rd, 8'h3c);
    host.sel_read(15'h7ff7, 1'b0, rd);
    chk1(data_oe, 1'b0);
    host.idle();
    host.bus_write(15'h0011, 8'h5a, 1'b1, ok);
    chk1(ok, 1'b1);
    rd_chk(15'h0011, 8'h5a);
    // leap-day rollover with unused bits set
    wr(CLOCK_CONTROL_OFS, 8'h95);
    rd_chk(CLOCK_CONTROL_OFS, 8'h95);
    for (int i = 0; i < 7; i++) wr(SECONDS_COUNT_OFS + 15'(i), tval[i]);
    for (int i = 0; i < 7; i++) rd_chk(SECONDS_COUNT_OFS + 15'(i), tval[i]);
    wr(CLOCK_CONTROL_OFS, 8'h15);
    host.step(30);
    for (int i = 1; i < 7; i++) rd_chk(SECONDS_COUNT_OFS + 15'(i), texp[i]);
    // frozen view while counting goes on
    wr(CLOCK_CONTROL_OFS, 8'h55);
    host.bus_read(SECONDS_COUNT_OFS, prev, ok);
    host.step(60);
    rd_chk(SECONDS_COUNT_OFS, prev);
    wr(CLOCK_CONTROL_OFS, 8'h15);
    host.step(25);
    host.bus_read(SECONDS_COUNT_OFS, rd, ok);
    chk1(rd !== prev, 1'b1);
    // oscillator stop, then test wave on the seconds lsb
    wr(CLOCK_CONTROL_OFS, 8'h95);
    wr(SECONDS_COUNT_OFS, 8'h90);
    wr(CLOCK_CONTROL_OFS, 8'h15);
    host.step(60);
    rd_chk(SECONDS_COUNT_OFS, 8'h90);
    wr(WEEKDAY_COUNT_OFS, 8'hf1);
    wr(SECONDS_COUNT_OFS, 8'h10);
    host.sel_read(SECONDS_COUNT_OFS, 1'b1, rd);
    last = data_out[0];
    toggles = 0;
    for (int i = 0; i < 40; i++) begin
      host.step(1);
      if (data_out[0] !== last) toggles++;
      last = data_out[0];
    end
    chk1(toggles >= 9 && toggles <= 11, 1'b1);
    host.idle();
    wr(WEEKDAY_COUNT_OFS, 8'hb1);
    // power-fail lockout
    power_fail_in = 1'b1;
    host.step(4);
    chk1(power_fail_flag_n, 1'b0);
    host.bus_read(15'h0010, rd, ok);
    chk1(ok, 1'b0);
    wr(15'h0010, 8'h00);
    host.step(40);
    chk1(power_fail_flag_n, 1'b0);
    power_fail_in = 1'b0;
    host.step(4);
    chk1(power_fail_flag_n, 1'b1);
    rd_chk(15'h0010, 8'ha5);
    host.bus_read(SECONDS_COUNT_OFS, rd, ok);
    chk1(rd !== 8'h10, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
